//--- core/baud_pkg.sv
package baud_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_DIV_CTRL  = 8'h00;
   localparam logic [7:0] OFS_FRAC_CTRL = 8'h04;
   localparam logic [7:0] OFS_MODE_CTRL = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0C;

   // Divider, fraction and mode control fields
   localparam int DIV_N_LSB     = 0;
   localparam int DIV_N_MSB     = 3;
   localparam int DIV_SEL_LSB   = 4;
   localparam int DIV_SEL_MSB   = 5;
   localparam int DIV_FRAC_EN   = 6;
   localparam int DIV_CTRL_MSB  = 7;
   localparam int FRAC_K_MSB    = 3;
   localparam int MODE_UART     = 0;
   localparam int MODE_DBL_BUF  = 1;

   // Status fields
   localparam int STAT_PHASE_LSB = 0;
   localparam int STAT_CNT_LSB   = 4;
   localparam int STAT_FRAC_ON   = 9;

   // Reset values
   localparam logic [7:0] RST_DIV_CTRL  = 8'h00;
   localparam logic [3:0] RST_FRAC_CTRL = 4'h0;
   localparam logic [1:0] RST_MODE_CTRL = 2'h0;

   // Input clock select codes
   localparam logic [1:0] SEL_DIV1  = 2'h0;
   localparam logic [1:0] SEL_DIV4  = 2'h1;
   localparam logic [1:0] SEL_DIV16 = 2'h2;
   localparam logic [1:0] SEL_DIV64 = 2'h3;

   // Prescaler tap masks and divider constants
   localparam logic [5:0] MASK_DIV4   = 6'h03;
   localparam logic [5:0] MASK_DIV16  = 6'h0F;
   localparam logic [5:0] MASK_DIV64  = 6'h3F;
   localparam logic [4:0] N_ZERO_CODE = 5'h10;
   localparam logic [4:0] FRAC_STEPS  = 5'h10;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

endpackage

//--- core/serial_baud_rate_divider.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module serial_baud_rate_divider (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // Register bus
   input  wire baud_pkg::wb_req_t wb_req,
   output logic                   wb_ack,
   output logic [31:0]            wb_dat_o,
   // Generator output
   output logic                   baud_tick,
   output logic                   frac_active
);

   logic [7:0]  div_ctrl_ff;
   logic [3:0]  frac_k_ff;
   logic [1:0]  mode_ff;
   logic        ack_ff;
   logic [31:0] rdat_ff;
   logic [5:0]  pre_ff;
   logic [4:0]  cnt_ff;
   logic [3:0]  phase_ff;
   logic        tick_ff;
   logic        tap_pulse;
   logic        frac_on;
   logic [4:0]  n_val;
   logic [4:0]  period;
   logic        long_slot;
   logic        bus_req;
   logic        bus_wr;
   logic [1:0]  clk_sel;
   logic [31:0] nxt_rdat;

   assign bus_req  = wb_req.cyc & wb_req.stb & ~ack_ff;
   assign bus_wr   = bus_req & wb_req.we & wb_req.sel[0];
   assign wb_ack   = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign clk_sel  = div_ctrl_ff[baud_pkg::DIV_SEL_MSB:baud_pkg::DIV_SEL_LSB];

   // Bus answer one cycle after request
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= bus_req;
      end
   end

   // Register writes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_ctrl_ff <= baud_pkg::RST_DIV_CTRL;
         frac_k_ff   <= baud_pkg::RST_FRAC_CTRL;
         mode_ff     <= baud_pkg::RST_MODE_CTRL;
      end else if (bus_wr) begin
         case (wb_req.adr)
            baud_pkg::OFS_DIV_CTRL: begin
               div_ctrl_ff <= wb_req.dat[baud_pkg::DIV_CTRL_MSB:0];
            end
            baud_pkg::OFS_FRAC_CTRL: begin
               frac_k_ff <= wb_req.dat[baud_pkg::FRAC_K_MSB:0];
            end
            baud_pkg::OFS_MODE_CTRL: begin
               mode_ff <= wb_req.dat[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux
   always_comb begin
      nxt_rdat = 32'h0000_0000;
      case (wb_req.adr)
         baud_pkg::OFS_DIV_CTRL: begin
            nxt_rdat[7:0] = div_ctrl_ff;
         end
         baud_pkg::OFS_FRAC_CTRL: begin
            nxt_rdat[3:0] = frac_k_ff;
         end
         baud_pkg::OFS_MODE_CTRL: begin
            nxt_rdat[1:0] = mode_ff;
         end
         baud_pkg::OFS_STATUS: begin
            nxt_rdat[baud_pkg::STAT_PHASE_LSB +: 4] = phase_ff;
            nxt_rdat[baud_pkg::STAT_CNT_LSB +: 5]   = cnt_ff;
            nxt_rdat[baud_pkg::STAT_FRAC_ON]        = frac_on;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdat_ff <= 32'h0000_0000;
      end else if (bus_req) begin
         rdat_ff <= nxt_rdat;
      end
   end

   // Prescaler and tap selection
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_ff <= 6'h00;
      end else begin
         pre_ff <= pre_ff + 6'h01;
      end
   end

   always_comb begin
      case (clk_sel)
         baud_pkg::SEL_DIV1:  tap_pulse = 1'b1;
         baud_pkg::SEL_DIV4:  tap_pulse = (pre_ff & baud_pkg::MASK_DIV4) == baud_pkg::MASK_DIV4;
         baud_pkg::SEL_DIV16: tap_pulse = (pre_ff & baud_pkg::MASK_DIV16) == baud_pkg::MASK_DIV16;
         default:             tap_pulse = pre_ff == baud_pkg::MASK_DIV64;
      endcase
   end

   // Divisor decode
   assign n_val = (div_ctrl_ff[baud_pkg::DIV_N_MSB:baud_pkg::DIV_N_LSB] == 4'h0) ?
                  baud_pkg::N_ZERO_CODE :
                  {1'b0, div_ctrl_ff[baud_pkg::DIV_N_MSB:baud_pkg::DIV_N_LSB]};
   assign frac_on     = div_ctrl_ff[baud_pkg::DIV_FRAC_EN]
                        & mode_ff[baud_pkg::MODE_UART];
   assign long_slot   = frac_on & ({1'b0, phase_ff}
                        < (baud_pkg::FRAC_STEPS - {1'b0, frac_k_ff}));
   assign period      = n_val + {4'h0, long_slot};
   assign frac_active = frac_on;
   assign baud_tick   = tick_ff;

   // Period counter
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff  <= 5'h00;
         tick_ff <= 1'b0;
      end else if (tap_pulse && (cnt_ff >= period - 5'h01)) begin
         cnt_ff  <= 5'h00;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= tap_pulse ? cnt_ff + 5'h01 : cnt_ff;
         tick_ff <= 1'b0;
      end
   end

   // Fraction phase
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_ff <= 4'h0;
      end else if (!frac_on) begin
         phase_ff <= 4'h0;
      end else if (tap_pulse && (cnt_ff >= period - 5'h01)) begin
         phase_ff <= phase_ff + 4'h1;
      end
   end

   // Checking helpers
   logic [5:0] taps_seen_ff;
   logic       dirty_ff;
   logic [4:0] exp_period_ff;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         taps_seen_ff  <= 6'h00;
         dirty_ff      <= 1'b1;
         exp_period_ff <= 5'h00;
      end else begin
         if (tap_pulse && (cnt_ff >= period - 5'h01)) begin
            taps_seen_ff  <= 6'h00;
            dirty_ff      <= bus_wr;
            exp_period_ff <= period;
         end else begin
            taps_seen_ff <= tap_pulse ? taps_seen_ff + 6'h01 : taps_seen_ff;
            dirty_ff     <= dirty_ff | bus_wr;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_int_period: assert property (
      (tap_pulse && (cnt_ff >= period - 5'h01) && !frac_on && !dirty_ff)
      |-> ({1'b0, taps_seen_ff} == {2'b00, n_val} - 7'h01))
      else $error("integer period differs from N");

   a_frac_period: assert property (
      (tap_pulse && (cnt_ff >= period - 5'h01) && frac_on && !dirty_ff)
      |-> ({1'b0, taps_seen_ff} == {2'b00, n_val} + {6'h00, long_slot} - 7'h01))
      else $error("fractional period differs from N or N+1");

   a_frac_slots: assert property (
      (frac_on && phase_ff == 4'h0 && frac_k_ff == 4'hF && $stable(div_ctrl_ff))
      |-> long_slot)
      else $error("first slot of a cycle is not long");

   a_uart_only: assert property (
      !mode_ff[baud_pkg::MODE_UART] |-> !frac_active ##1 (phase_ff == 4'h0))
      else $error("fraction active outside UART mode");

   a_tap_div4: assert property (
      (tap_pulse && clk_sel == baud_pkg::SEL_DIV4 && !bus_wr)
      |=> (!tap_pulse || clk_sel != baud_pkg::SEL_DIV4) [*3])
      else $error("divide-by-4 tap fires too early");

   a_tap_div1: assert property (
      (clk_sel == baud_pkg::SEL_DIV1) |-> tap_pulse)
      else $error("divide-by-1 tap missing");

   a_bus_ack: assert property (
      (wb_req.cyc && wb_req.stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
      else $error("bus ack not a single cycle after request");

endmodule

//--- sim/serial_baud_rate_divider_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module serial_baud_rate_divider_tb_top;
   typedef struct {
      logic [7:0] dc;
      logic [3:0] k;
      logic [1:0] md;
      int         tot;
      logic       fa;
   } row_t;
   logic              ref_clk = 1'b0;
   logic              rst_b   = 1'b0;
   baud_pkg::wb_req_t wb_req  = '0;
   logic              wb_ack;
   logic [31:0]       wb_dat_o;
   logic              baud_tick;
   logic              frac_active;
   logic [31:0]       rd;
   int                error_cnt = 0;
   int                compares  = 0;
   int                tot;
   // Divider control, K, mode, cycles for 16 periods, fraction flag
   row_t rows [8] = '{
      '{8'h02, 4'h1, 2'h0, 32,   1'b0},
      '{8'h00, 4'h1, 2'h0, 256,  1'b0},
      '{8'h13, 4'h1, 2'h0, 192,  1'b0},
      '{8'h21, 4'h1, 2'h2, 256,  1'b0},
      '{8'h32, 4'h1, 2'h0, 2048, 1'b0},
      '{8'h43, 4'h5, 2'h1, 59,   1'b1},
      '{8'h43, 4'h5, 2'h0, 48,   1'b0},
      '{8'h5F, 4'hF, 2'h1, 964,  1'b1}};
   serial_baud_rate_divider DUT (
      .ref_clk     (ref_clk),
      .rst_b       (rst_b),
      .wb_req      (wb_req),
      .wb_ack      (wb_ack),
      .wb_dat_o    (wb_dat_o),
      .baud_tick   (baud_tick),
      .frac_active (frac_active)
   );
   always #2.5 ref_clk = ~ref_clk;
   task automatic finish_test();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One classic cycle, held until ack is sampled
   task automatic wb(input logic [7:0] a, input logic we, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
      do begin
         @(posedge ref_clk);
      end while (wb_ack !== 1'b1);
      q = wb_dat_o;
      wb_req <= '0;
      @(posedge ref_clk);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(a, 1'b0, 4'hF, 32'h0, q);
      `CHK(q, e)
   endtask
   // Cycles spanned by 16 output periods, after two settling ticks
   task automatic measure(output int c);
      int n;
      c = 0;
      n = -2;
      while (n < 16 && c < 20000) begin
         @(posedge ref_clk);
         if (n >= 0) c++;
         if (baud_tick === 1'b1) n++;
      end
   endtask
   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (16) @(posedge ref_clk);
      `CHK(baud_tick, 1'b0)
      `CHK(frac_active, 1'b0)
      `CHK(wb_ack, 1'b0)
      `CHK(wb_dat_o, 32'h0000_0000)
      rst_b <= 1'b1;
      chk_rd(baud_pkg::OFS_DIV_CTRL, 32'h0);
      chk_rd(baud_pkg::OFS_FRAC_CTRL, 32'h0);
      chk_rd(baud_pkg::OFS_MODE_CTRL, 32'h0);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      do_reset();
      foreach (rows[i]) begin
         // Fraction off before K changes, enable written last
         wb(baud_pkg::OFS_DIV_CTRL, 1'b1, 4'hF, {24'h0, rows[i].dc & 8'hBF}, rd);
         wb(baud_pkg::OFS_FRAC_CTRL, 1'b1, 4'hF, {28'h0, rows[i].k}, rd);
         wb(baud_pkg::OFS_MODE_CTRL, 1'b1, 4'hF, {30'h0, rows[i].md}, rd);
         wb(baud_pkg::OFS_DIV_CTRL, 1'b1, 4'hF, {24'h0, rows[i].dc}, rd);
         chk_rd(baud_pkg::OFS_DIV_CTRL, {24'h0, rows[i].dc});
         measure(tot);
         `CHK(tot, rows[i].tot)
         `CHK(frac_active, rows[i].fa)
      end
      // Upper bits read zero, unmapped and read-only places ignore writes
      wb(baud_pkg::OFS_DIV_CTRL, 1'b1, 4'hF, 32'h0000_001F, rd);
      wb(baud_pkg::OFS_FRAC_CTRL, 1'b1, 4'hF, 32'hFFFF_FFF3, rd);
      chk_rd(baud_pkg::OFS_FRAC_CTRL, 32'h3);
      wb(baud_pkg::OFS_FRAC_CTRL, 1'b1, 4'hE, 32'h0000_0009, rd);
      chk_rd(baud_pkg::OFS_FRAC_CTRL, 32'h3);
      wb(baud_pkg::OFS_DIV_CTRL, 1'b1, 4'hF, 32'h0000_005F, rd);
      wb(baud_pkg::OFS_STATUS, 1'b1, 4'hF, 32'h0000_03FF, rd);
      wb(baud_pkg::OFS_STATUS, 1'b0, 4'hF, 32'h0000_0000, rd);
      `CHK(rd[31:9], 23'h000001)
      wb(8'h10, 1'b1, 4'hF, 32'h0000_00FF, rd);
      chk_rd(8'h10, 32'h0);
      chk_rd(baud_pkg::OFS_DIV_CTRL, 32'h5F);
      // K of 3 with N of 15 on the divide-by-4 tap: (240 + 13) x 4
      measure(tot);
      `CHK(tot, 1012)
      // Second reset in mid-run
      do_reset();
      measure(tot);
      `CHK(tot, 256)
      finish_test();
   end
endmodule
